// ---- pkg/crtc_pkg.sv ----
package crtc_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_DIV    = 8'h00;  // Divider minus one
  localparam logic [7:0] OFS_SETUP0 = 8'h04;  // Setup year, month, day
  localparam logic [7:0] OFS_SETUP1 = 8'h08;  // Setup weekday, hour, minute, second
  localparam logic [7:0] OFS_CTRL   = 8'h0c;  // Control and status
  localparam logic [7:0] OFS_ALARM0 = 8'h10;  // Alarm date and enables
  localparam logic [7:0] OFS_ALARM1 = 8'h14;  // Alarm time and enables
  localparam logic [7:0] OFS_TIME1  = 8'h18;  // Current date, snapshot
  localparam logic [7:0] OFS_TIME0  = 8'h1c;  // Current time, latches date
  // Field widths
  localparam int YEAR_W = 12;
  localparam int MON_W  = 4;
  localparam int DAY_W  = 5;
  localparam int DOW_W  = 3;
  localparam int HOUR_W = 5;
  localparam int MIN_W  = 6;
  localparam int SEC_W  = 6;
  localparam int DIV_W  = 16;
  // Field positions in date words
  localparam int YEAR_LSB = 12;
  localparam int MON_LSB  = 8;
  localparam int DAY_LSB  = 0;
  // Field positions in time words
  localparam int DOW_LSB  = 24;
  localparam int HOUR_LSB = 16;
  localparam int MIN_LSB  = 8;
  localparam int SEC_LSB  = 0;
  // Control bits
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_RUN_BIT  = 1;
  localparam int CTRL_LOAD_BIT = 4;
  localparam int CTRL_INH_BIT  = 8;
  // Alarm enables: date word bits 28..24, time word bits 31..28
  localparam int AL_GLOBAL_BIT = 28;
  localparam int AL_YEAR_BIT   = 26;
  localparam int AL_MON_BIT    = 25;
  localparam int AL_DAY_BIT    = 24;
  localparam int AL_DOW_BIT    = 31;
  localparam int AL_HOUR_BIT   = 30;
  localparam int AL_MIN_BIT    = 29;
  localparam int AL_SEC_BIT    = 28;
  // Reference periods between a write and its effect
  localparam logic [1:0] XFER_REF_PERIODS = 2'd2;
  // Calendar limits
  localparam logic [SEC_W-1:0]  SEC_LAST   = 6'd59;
  localparam logic [MIN_W-1:0]  MIN_LAST   = 6'd59;
  localparam logic [HOUR_W-1:0] HOUR_LAST  = 5'd23;
  localparam logic [DOW_W-1:0]  DOW_LAST   = 3'd6;
  localparam logic [MON_W-1:0]  MON_LAST   = 4'd12;
  localparam logic [MON_W-1:0]  MON_FEB    = 4'd2;
  localparam logic [DAY_W-1:0]  DAY_FIRST  = 5'd1;
  localparam logic [MON_W-1:0]  MON_FIRST  = 4'd1;
endpackage : crtc_pkg

// ---- rtl/crtc_top.sv ----
`timescale 1ns/100ps
module crtc_top import crtc_pkg::*; (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Reference clock pin
  input  wire logic        ref_clk_in,
  // Alarm outputs
  output logic             alarm_irq,
  output logic             ring_oscillator_wake,
  output logic             crystal_oscillator_wake
);
  // Reference pin synchroniser and edge history
  logic              ref_s1_q, ref_s2_q, ref_s3_q;
  // Bus address phase capture
  logic              wr_pend_q;
  logic [7:0]        wr_addr_q;
  // Software side registers
  logic [31:0]       setup0_q, setup1_q, alarm0_q, alarm1_q;
  logic [DIV_W-1:0]  div_q;
  logic              en_q, inh_q, load_q;
  logic [31:0]       snap1_q;               // Date snapshot taken on time read
  // Reference side copies
  logic [1:0]        xfer_q;                // Reference edges left before apply
  logic              act_en_q, act_inh_q;
  logic [DIV_W-1:0]  act_div_q, div_cnt_q;
  // Time counters
  logic [YEAR_W-1:0] year_q;
  logic [MON_W-1:0]  mon_q;
  logic [DAY_W-1:0]  day_q;
  logic [DOW_W-1:0]  dow_q;
  logic [HOUR_W-1:0] hour_q;
  logic [MIN_W-1:0]  min_q;
  logic [SEC_W-1:0]  sec_q;

  // Bus decode
  wire        addr_ph  = hsel & htrans[1] & hready;
  wire        rd_ph    = addr_ph & ~hwrite;
  wire [7:0]  ra       = haddr[7:0];
  wire        wr_do    = wr_pend_q;
  wire [31:0] date_w   = {8'h00, year_q, mon_q, 3'b000, day_q};
  wire [31:0] time_w   = {5'h00, dow_q, 3'b000, hour_q, 2'b00, min_q, 2'b00, sec_q};
  wire [31:0] ctrl_w   = {23'h0, inh_q, 3'b000, load_q, 2'b00, act_en_q, en_q};
  wire [31:0] rd_word  = (ra == OFS_DIV)    ? {16'h0000, div_q} :
                         (ra == OFS_SETUP0) ? setup0_q :
                         (ra == OFS_SETUP1) ? setup1_q :
                         (ra == OFS_CTRL)   ? ctrl_w :
                         (ra == OFS_ALARM0) ? alarm0_q :
                         (ra == OFS_ALARM1) ? alarm1_q :
                         (ra == OFS_TIME1)  ? snap1_q :
                         (ra == OFS_TIME0)  ? time_w : 32'h0000_0000;

  // Reference timing: edge, transfer apply and divider tick
  wire ref_edge = ref_s2_q & ~ref_s3_q;
  wire apply    = ref_edge & (xfer_q == 2'd1);
  wire tick     = ref_edge & (div_cnt_q == act_div_q);
  wire do_load  = apply & load_q;
  wire inc      = tick & act_en_q & ~do_load;

  // Calendar carries
  wire leap     = (year_q[1:0] == 2'b00) & ~act_inh_q;
  wire [DAY_W-1:0] last_day =
    (mon_q == MON_FEB) ? (leap ? 5'd29 : 5'd28) :
    (mon_q == 4'd4 || mon_q == 4'd6 || mon_q == 4'd9 || mon_q == 4'd11) ? 5'd30 : 5'd31;
  wire c_sec  = inc & (sec_q == SEC_LAST);
  wire c_min  = c_sec & (min_q == MIN_LAST);
  wire c_hour = c_min & (hour_q == HOUR_LAST);
  wire c_day  = c_hour & (day_q == last_day);
  wire c_mon  = c_day & (mon_q == MON_LAST);

  // Alarm match, disabled fields count as matched
  wire m_year = ~alarm0_q[AL_YEAR_BIT] | (alarm0_q[YEAR_LSB +: YEAR_W] == year_q);
  wire m_mon  = ~alarm0_q[AL_MON_BIT]  | (alarm0_q[MON_LSB +: MON_W] == mon_q);
  wire m_day  = ~alarm0_q[AL_DAY_BIT]  | (alarm0_q[DAY_LSB +: DAY_W] == day_q);
  wire m_dow  = ~alarm1_q[AL_DOW_BIT]  | (alarm1_q[DOW_LSB +: DOW_W] == dow_q);
  wire m_hour = ~alarm1_q[AL_HOUR_BIT] | (alarm1_q[HOUR_LSB +: HOUR_W] == hour_q);
  wire m_min  = ~alarm1_q[AL_MIN_BIT]  | (alarm1_q[MIN_LSB +: MIN_W] == min_q);
  wire m_sec  = ~alarm1_q[AL_SEC_BIT]  | (alarm1_q[SEC_LSB +: SEC_W] == sec_q);
  wire alarm_d = alarm0_q[AL_GLOBAL_BIT] & m_year & m_mon & m_day & m_dow & m_hour & m_min & m_sec;

  // Reference pin synchroniser and edge history
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      {ref_s1_q, ref_s2_q, ref_s3_q} <= 3'b000;
    end else begin
      {ref_s1_q, ref_s2_q, ref_s3_q} <= {ref_clk_in, ref_s1_q, ref_s2_q};
    end
  end

  // Bus response, zero wait states, always OKAY
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= addr_ph & hwrite;
      wr_addr_q <= ra;
      hreadyout <= 1'b1;
      if (rd_ph) begin
        hrdata <= rd_word;
      end
    end
  end

  // Date snapshot: reading the time word latches the date word
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      snap1_q <= 32'h0000_0000;
    end else if (rd_ph && ra == OFS_TIME0) begin
      snap1_q <= date_w;
    end
  end

  // Software registers; a new load request wins over its clear
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      setup0_q <= 32'h0000_0000;
      setup1_q <= 32'h0000_0000;
      alarm0_q <= 32'h0000_0000;
      alarm1_q <= 32'h0000_0000;
      div_q    <= '0;
      en_q     <= 1'b0;
      inh_q    <= 1'b0;
      load_q   <= 1'b0;
    end else begin
      if (do_load) begin
        load_q <= 1'b0;
      end
      if (wr_do) begin
        unique case (wr_addr_q)
          OFS_DIV:    div_q    <= hwdata[DIV_W-1:0];
          OFS_SETUP0: setup0_q <= hwdata & 32'h00ff_ff1f;
          OFS_SETUP1: setup1_q <= hwdata & 32'h071f_3f3f;
          OFS_CTRL: begin
            en_q  <= hwdata[CTRL_EN_BIT];
            inh_q <= hwdata[CTRL_INH_BIT];
            if (hwdata[CTRL_LOAD_BIT]) begin
              load_q <= 1'b1;
            end
          end
          OFS_ALARM0: alarm0_q <= hwdata & 32'h17ff_ff1f;
          OFS_ALARM1: alarm1_q <= hwdata & 32'hf71f_3f3f;
          default: ;
        endcase
      end
    end
  end

  // Transfer to reference side two reference periods after a write
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      xfer_q    <= 2'd0;
      act_en_q  <= 1'b0;
      act_inh_q <= 1'b0;
      act_div_q <= '0;
    end else begin
      if (wr_do) begin
        xfer_q <= XFER_REF_PERIODS;
      end else if (ref_edge && xfer_q != 2'd0) begin
        xfer_q <= xfer_q - 2'd1;
      end
      if (apply) begin
        act_en_q  <= en_q;
        act_inh_q <= inh_q;
        act_div_q <= div_q;
      end
    end
  end

  // One second divider
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      div_cnt_q <= '0;
    end else if (!act_en_q || tick) begin
      div_cnt_q <= '0;
    end else if (ref_edge) begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  // Time counters: load copies setup, tick advances
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      {year_q, mon_q, day_q, dow_q, hour_q, min_q, sec_q} <= '0;
    end else if (do_load) begin
      year_q <= setup0_q[YEAR_LSB +: YEAR_W];
      mon_q  <= setup0_q[MON_LSB +: MON_W];
      day_q  <= setup0_q[DAY_LSB +: DAY_W];
      dow_q  <= setup1_q[DOW_LSB +: DOW_W];
      hour_q <= setup1_q[HOUR_LSB +: HOUR_W];
      min_q  <= setup1_q[MIN_LSB +: MIN_W];
      sec_q  <= setup1_q[SEC_LSB +: SEC_W];
    end else if (inc) begin
      sec_q <= c_sec ? '0 : sec_q + 6'd1;
      if (c_sec) begin
        min_q <= c_min ? '0 : min_q + 6'd1;
      end
      if (c_min) begin
        hour_q <= c_hour ? '0 : hour_q + 5'd1;
      end
      if (c_hour) begin
        dow_q <= (dow_q == DOW_LAST) ? '0 : dow_q + 3'd1;
        day_q <= c_day ? DAY_FIRST : day_q + 5'd1;
      end
      if (c_day) begin
        mon_q <= c_mon ? MON_FIRST : mon_q + 4'd1;
      end
      if (c_mon) begin
        year_q <= year_q + 12'd1;
      end
    end
  end

  // Alarm level to processors and both oscillators
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      alarm_irq               <= 1'b0;
      ring_oscillator_wake    <= 1'b0;
      crystal_oscillator_wake <= 1'b0;
    end else begin
      alarm_irq               <= alarm_d;
      ring_oscillator_wake    <= alarm_d;
      crystal_oscillator_wake <= alarm_d;
    end
  end

  // Checks
  a_sec_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
    c_sec |=> sec_q == 6'd0 && min_q == $past(min_q) + 6'd1 || $past(c_min))
    else $error("second carry wrong");
  a_dow_wrap: assert property (@(posedge sys_clk) disable iff (!rstn)
    c_hour && dow_q == 3'd6 |=> dow_q == 3'd0)
    else $error("weekday wrap wrong");
  a_leap_feb: assert property (@(posedge sys_clk) disable iff (!rstn)
    c_hour && mon_q == 4'd2 && day_q == 5'd28 && year_q[1:0] == 2'b00 && !act_inh_q
    |=> day_q == 5'd29 && mon_q == 4'd2)
    else $error("leap day skipped");
  a_leap_inh: assert property (@(posedge sys_clk) disable iff (!rstn)
    c_hour && mon_q == 4'd2 && day_q == 5'd28 && act_inh_q |=> day_q == 5'd1 && mon_q == 4'd3)
    else $error("inhibit ignored");
  a_tick_div: assert property (@(posedge sys_clk) disable iff (!rstn)
    act_en_q && ref_edge && !tick && !apply |=> div_cnt_q == $past(div_cnt_q) + 16'h0001)
    else $error("divider count wrong");
  a_alarm_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
    !alarm0_q[AL_GLOBAL_BIT] |=> !alarm_irq)
    else $error("alarm without global enable");
  a_wake_same: assert property (@(posedge sys_clk) disable iff (!rstn)
    alarm_irq == ring_oscillator_wake && alarm_irq == crystal_oscillator_wake)
    else $error("wake differs from alarm");
  a_load_copy: assert property (@(posedge sys_clk) disable iff (!rstn)
    do_load |=> sec_q == $past(setup1_q[5:0]) && day_q == $past(setup0_q[4:0]))
    else $error("load not copied");
  a_write_delay: assert property (@(posedge sys_clk) disable iff (!rstn)
    wr_do |=> xfer_q == 2'd2)
    else $error("transfer not armed");
endmodule : crtc_top

// ---- dv/crtc_tb.sv ----
`timescale 1ns/100ps
module tb import crtc_pkg::*; ;
  // Bus, reference and alarm signals
  logic        sys_clk, rstn, hsel, hwrite;
  logic        ref_clk_in = 1'b0;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hready, hreadyout, hresp, alarm_irq, ring_w, xtal_w;
  int          n_mismatch, cmp_count;
  int          cyc = 0;
  // The one slave drives the bus ready
  assign hready = hreadyout;
  crtc_top DUT (.sys_clk(sys_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ref_clk_in(ref_clk_in), .alarm_irq(alarm_irq),
    .ring_oscillator_wake(ring_w), .crystal_oscillator_wake(xtal_w));
  // System clock, 10 ns
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Final counts and verdict
  task automatic wrap_up;
    $display("Counts: %0d mismatches, %0d compares", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up
  // Reference runs from time zero, period of eight system cycles; hang guard
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) ref_clk_in <= ~ref_clk_in;
    if (cyc == 60000) begin
      $display("Error at %0t: timeout", $time);
      n_mismatch++;
      wrap_up();
    end
  end
  // One comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : chk
  // Single word transfer, waits on ready in both phases
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, rd);
  endtask : wr
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0, rd);
    chk(rd & m, e, "read");
  endtask : rdm
  // Read until a bit takes a value, bounded
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int k;
    k = 0;
    do begin
      bus(1'b0, a, 32'h0, rd);
      k++;
    end while (rd[b] !== v && k < 50);
    chk(rd[b], v, "poll");
  endtask : poll
  // Date and time word builders
  function automatic logic [31:0] dw(input logic [11:0] y, input logic [3:0] m, input logic [4:0] d);
    return {8'h0, y, m, 3'h0, d};
  endfunction : dw
  function automatic logic [31:0] tw(input logic [2:0] w, input logic [4:0] h, input logic [5:0] mi,
                                     input logic [5:0] s);
    return {5'h0, w, 3'h0, h, 2'h0, mi, 2'h0, s};
  endfunction : tw
  // Stop, load setup words, then enable
  task automatic stop_clk(input logic [31:0] c);
    wr(OFS_CTRL, c);
    poll(OFS_CTRL, CTRL_RUN_BIT, 1'b0);
  endtask : stop_clk
  task automatic start_clk(input logic [31:0] c);
    wr(OFS_CTRL, c | 32'h10);
    poll(OFS_CTRL, CTRL_LOAD_BIT, 1'b0);
    wr(OFS_CTRL, c | 32'h1);
    poll(OFS_CTRL, CTRL_RUN_BIT, 1'b1);
  endtask : start_clk
  // Wait for the alarm, bounded
  task automatic wait_irq;
    int k;
    k = 0;
    while (alarm_irq !== 1'b1 && k < 2000) begin
      @(posedge sys_clk);
      k++;
    end
  endtask : wait_irq
  // Reset values, unmapped place, response
  task automatic t_reset;
    rdm(OFS_CTRL, 32'hffffffff, 32'h0);
    rdm(OFS_DIV, 32'hffffffff, 32'h0);
    wr(8'h40, 32'hffffffff);
    rdm(8'h40, 32'hffffffff, 32'h0);
    chk(hresp, 1'b0, "resp");
    chk(alarm_irq, 1'b0, "irq at reset");
    $display("test reset done");
  endtask : t_reset
  // Start one second before a rollover, full alarm on the expected next second
  task automatic t_case(input logic [31:0] s0, input logic [31:0] s1, input logic [31:0] e0,
                        input logic [31:0] e1, input logic inh);
    logic [31:0] c;
    c = {23'h0, inh, 8'h0};
    stop_clk(c);
    wr(OFS_DIV, 32'h3);
    wr(OFS_SETUP0, s0);
    wr(OFS_SETUP1, s1);
    wr(OFS_ALARM0, e0 | 32'h17000000);
    wr(OFS_ALARM1, e1 | 32'hf0000000);
    start_clk(c);
    wait_irq();
    chk(alarm_irq, 1'b1, "alarm");
    chk({ring_w, xtal_w}, 2'h3, "wake");
    rdm(OFS_TIME0, 32'h071f3f3f, e1);
    rdm(OFS_TIME1, 32'h00ffff1f, e0);
    $display("test rollover %h done", e0);
  endtask : t_case
  // Seconds-only alarm stays up one tick period
  task automatic t_period(input logic [15:0] dv);
    int n;
    stop_clk(32'h0);
    wr(OFS_DIV, {16'h0, dv});
    wr(OFS_SETUP1, tw(3'h0, 5'h1, 6'h2, 6'h3));
    wr(OFS_ALARM0, 32'h10000000);
    wr(OFS_ALARM1, tw(3'h0, 5'h0, 6'h0, 6'h5) | 32'h10000000);
    start_clk(32'h0);
    wait_irq();
    n = 0;
    while (alarm_irq === 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n, (dv + 1) * 8, "tick period");
    $display("test period %0d done", dv);
  endtask : t_period
  // Global enable gates the alarm; no field enables means always matched
  task automatic t_global;
    int k;
    wr(OFS_ALARM1, 32'h0);
    wr(OFS_ALARM0, 32'h0);
    repeat (40) @(posedge sys_clk);
    k = 0;
    repeat (64) begin
      @(posedge sys_clk);
      k += (alarm_irq !== 1'b0);
    end
    chk(k, 0, "alarm off");
    wr(OFS_ALARM0, 32'h10000000);
    repeat (40) @(posedge sys_clk);
    repeat (64) begin
      @(posedge sys_clk);
      k += (alarm_irq === 1'b1);
    end
    chk(k, 64, "alarm on");
    $display("test global done");
  endtask : t_global
  // Main sequence
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_case(dw(12'h7e8, 4'h2, 5'h1c), tw(3'h6, 5'h17, 6'h3b, 6'h3b), dw(12'h7e8, 4'h2, 5'h1d),
           tw(3'h0, 5'h0, 6'h0, 6'h0), 1'b0);
    t_case(dw(12'h7e8, 4'h2, 5'h1c), tw(3'h3, 5'h17, 6'h3b, 6'h3b), dw(12'h7e8, 4'h3, 5'h1),
           tw(3'h4, 5'h0, 6'h0, 6'h0), 1'b1);
    t_case(dw(12'h7e7, 4'h2, 5'h1c), tw(3'h2, 5'h17, 6'h3b, 6'h3b), dw(12'h7e7, 4'h3, 5'h1),
           tw(3'h3, 5'h0, 6'h0, 6'h0), 1'b0);
    t_case(dw(12'h7e7, 4'hc, 5'h1f), tw(3'h0, 5'h17, 6'h3b, 6'h3b), dw(12'h7e8, 4'h1, 5'h1),
           tw(3'h1, 5'h0, 6'h0, 6'h0), 1'b0);
    t_case(dw(12'h7e7, 4'h4, 5'h1e), tw(3'h5, 5'h17, 6'h3b, 6'h3b), dw(12'h7e7, 4'h5, 5'h1),
           tw(3'h6, 5'h0, 6'h0, 6'h0), 1'b0);
    t_period(16'h0);
    t_period(16'h3);
    t_global();
    wrap_up();
  end
endmodule : tb
